// [verilog/acd_top.sv]
`timescale 1ns/1ps
// How it works
// - channel-disable register at 0x27, defaults restore zero
// - bit 7 disables input current conversion
// - bit 6 disables battery current conversion
// - bit 5 disables input voltage conversion
// - bit 4 disables battery voltage conversion
// - bit 3 disables system voltage conversion
// - bit 2 disables thermistor conversion
// - convert only when on; results hold values
// - rate bit: continuous or one-shot pass
module acd_top
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  input  wire logic        REG_DEFAULTS,
  output logic             CONV_START,
  output logic      [2:0]  CONV_CH,
  input  wire logic        CONV_DONE,
  input  wire logic [15:0] CONV_DATA,
  input  wire logic [2:0]  RES_CH,
  output logic      [15:0] RES_DATA,
  output logic             CONV_BUSY
);

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]             ctrl_reg;
  logic [7:0]             dis_reg;
  logic [7:0]             rdata_reg;
  acd_pkg::acd_state_t    state_reg;
  logic [2:0]             ch_reg;
  logic                   start_reg;
  logic [2:0]             conv_ch_reg;
  logic                   busy_reg;
  logic                   pass_done;
  logic                   ch_off;
  logic                   wr_ctrl;
  logic                   wr_dis;

  // write decodes; a write to any other address is simply ignored
  assign wr_ctrl = REG_WR && (REG_ADDR == acd_pkg::ADDR_CONV_CTRL);
  assign wr_dis  = REG_WR && (REG_ADDR == acd_pkg::ADDR_CHAN_DISABLE);

  // channel n is governed by disable bit (7 - n)
  // the subtraction stays in three bits; channels 6 and 7 would alias onto
  // the reserved bits, but the sequencer never points at them
  assign ch_off  = dis_reg[3'd7 - ch_reg];

  // end of a pass: last channel just finished or was skipped
  // shared by the sequencer and the one-shot clear so both agree on the end
  assign pass_done = (ch_reg == acd_pkg::CH_LAST) &&
                     (((state_reg == acd_pkg::ACD_SCAN) && ch_off) ||
                      ((state_reg == acd_pkg::ACD_WAIT) && CONV_DONE));

  // disable register, restore to all enabled
  // current, voltage and thermistor disables
  // six read-write bits; the low two are reserved and always read zero
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      dis_reg <= acd_pkg::DIS_RESET;
    else if (REG_DEFAULTS)
      dis_reg <= acd_pkg::DIS_RESET;
    else if (wr_dis)
      dis_reg <= REG_WDATA & acd_pkg::DIS_WRITE_MASK;
  end

  // master on bit; rate select
  // one-shot clears the on bit at pass end, but a software write in that
  // same cycle wins so a fresh start is never lost
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      ctrl_reg <= acd_pkg::CTRL_RESET;
    else if (REG_DEFAULTS)
      ctrl_reg <= acd_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl_reg <= REG_WDATA & acd_pkg::CTRL_WRITE_MASK;
    else if (pass_done && ctrl_reg[acd_pkg::CTRL_RATE_BIT])
      ctrl_reg[acd_pkg::CTRL_ON_BIT] <= 1'b0;
  end

  // register read, one cycle after the strobe; unmapped reads zero
  // a read never disturbs the registers, so a stray strobe is harmless
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      rdata_reg <= 8'h00;
    else if (REG_RD)
    begin
      case (REG_ADDR)
        acd_pkg::ADDR_CONV_CTRL:    rdata_reg <= ctrl_reg;
        acd_pkg::ADDR_CHAN_DISABLE: rdata_reg <= dis_reg;
        default:                    rdata_reg <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel sequencer

  // skip disabled channels, one per cycle
  // conversions only start while the on bit is set; a conversion in
  // flight is always allowed to finish so the converter is never left hung
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_reg <= acd_pkg::ACD_IDLE;
      ch_reg    <= acd_pkg::CH_FIRST;
    end
    else
    begin
      case (state_reg)
        acd_pkg::ACD_IDLE:
        begin
          // pointer parked at the first channel so every pass starts there
          ch_reg <= acd_pkg::CH_FIRST;
          if (ctrl_reg[acd_pkg::CTRL_ON_BIT])
            state_reg <= acd_pkg::ACD_SCAN;
        end
        acd_pkg::ACD_SCAN:
        begin
          if (!ctrl_reg[acd_pkg::CTRL_ON_BIT])
            state_reg <= acd_pkg::ACD_IDLE;
          else if (!ch_off)
            state_reg <= acd_pkg::ACD_WAIT;
          else if (pass_done)
          begin
            ch_reg <= acd_pkg::CH_FIRST;
            if (ctrl_reg[acd_pkg::CTRL_RATE_BIT])
              state_reg <= acd_pkg::ACD_IDLE;
          end
          else
            ch_reg <= ch_reg + 3'd1;
        end
        acd_pkg::ACD_WAIT:
        begin
          // a result that lands after the on bit falls is still stored
          if (CONV_DONE)
          begin
            if (pass_done)
              ch_reg <= acd_pkg::CH_FIRST;
            else
              ch_reg <= ch_reg + 3'd1;
            if (!ctrl_reg[acd_pkg::CTRL_ON_BIT] ||
                (pass_done && ctrl_reg[acd_pkg::CTRL_RATE_BIT]))
              state_reg <= acd_pkg::ACD_IDLE;
            else
              state_reg <= acd_pkg::ACD_SCAN;
          end
        end
        default:
        begin
          state_reg <= acd_pkg::ACD_IDLE;
          ch_reg    <= acd_pkg::CH_FIRST;
        end
      endcase
    end
  end

  // start pulse and channel number to the converter front end
  // the channel number is held after the pulse so the front end may latch
  // it late without a race against the next scan step
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      start_reg   <= 1'b0;
      conv_ch_reg <= acd_pkg::CH_FIRST;
    end
    else
    begin
      start_reg <= (state_reg == acd_pkg::ACD_SCAN) &&
                   ctrl_reg[acd_pkg::CTRL_ON_BIT] && !ch_off;
      if (state_reg == acd_pkg::ACD_SCAN)
        conv_ch_reg <= ch_reg;
    end
  end

  // busy while a pass is underway or a conversion is outstanding
  // lags the state by one cycle: a poller must not trust it right after
  // setting the on bit
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      busy_reg <= 1'b0;
    else
      busy_reg <= (state_reg != acd_pkg::ACD_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // result store

  // results kept in their own store so the read port stays registered
  acd_mem_if mem_bus ();

  // results written only on a finished conversion
  // a skipped channel never writes, so it keeps its old value
  assign mem_bus.wr_en   = (state_reg == acd_pkg::ACD_WAIT) && CONV_DONE;
  assign mem_bus.wr_ch   = ch_reg;
  assign mem_bus.wr_data = CONV_DATA;
  assign mem_bus.rd_ch   = RES_CH;

  acd_result_mem u_mem
  (
    .CLK   (CLK),
    .RST_N (RST_N),
    .port  (mem_bus.mem)
  );

  assign REG_RDATA  = rdata_reg;
  assign CONV_START = start_reg;
  assign CONV_CH    = conv_ch_reg;
  assign RES_DATA   = mem_bus.rd_data;
  assign CONV_BUSY  = busy_reg;

endmodule

// [pkg/acd_pkg.sv]
package acd_pkg;

  // register map
  localparam logic [7:0] ADDR_CONV_CTRL    = 8'h26;
  localparam logic [7:0] ADDR_CHAN_DISABLE = 8'h27;

  // converter control fields
  localparam int         CTRL_ON_BIT       = 7;
  localparam int         CTRL_RATE_BIT     = 6;
  localparam logic [7:0] CTRL_RESET        = 8'h00;
  localparam logic [7:0] CTRL_WRITE_MASK   = 8'hC0;

  // channel disable fields, channel n sits at bit (7 - n)
  localparam int         DIS_INPUT_CURRENT_BIT   = 7;
  localparam int         DIS_BATTERY_CURRENT_BIT = 6;
  localparam int         DIS_INPUT_VOLTAGE_BIT   = 5;
  localparam int         DIS_BATTERY_VOLTAGE_BIT = 4;
  localparam int         DIS_SYSTEM_VOLTAGE_BIT  = 3;
  localparam int         DIS_THERMISTOR_BIT      = 2;
  localparam logic [7:0] DIS_RESET               = 8'h00;
  localparam logic [7:0] DIS_WRITE_MASK          = 8'hFC;

  // converter channels and result store
  localparam int         NUM_CH      = 6;
  localparam int         CH_W        = 3;
  localparam int         RES_W       = 16;
  localparam logic [2:0] CH_FIRST    = 3'h0;
  localparam logic [2:0] CH_LAST     = 3'h5;
  localparam logic [15:0] RES_RESET  = 16'h0000;

  typedef enum logic [1:0] {
    ACD_IDLE = 2'b00,
    ACD_SCAN = 2'b01,
    ACD_WAIT = 2'b10
  } acd_state_t;

endpackage

// [pkg/acd_mem_if.sv]
`timescale 1ns/1ps
interface acd_mem_if;
  logic        wr_en;
  logic [2:0]  wr_ch;
  logic [15:0] wr_data;
  logic [2:0]  rd_ch;
  logic [15:0] rd_data;

  modport ctrl (output wr_en, output wr_ch, output wr_data,
                output rd_ch, input rd_data);
  modport mem  (input wr_en, input wr_ch, input wr_data,
                input rd_ch, output rd_data);
endinterface

// [verilog/acd_result_mem.sv]
`timescale 1ns/1ps
module acd_result_mem
(
  input  wire logic  CLK,
  input  wire logic  RST_N,
  acd_mem_if.mem     port
);

  logic [15:0] res_reg [acd_pkg::NUM_CH];
  logic [15:0] rd_data_reg;

  // one held value per channel; power-on clears, nothing else does
  genvar g;
  generate
    for (g = 0; g < acd_pkg::NUM_CH; g++)
    begin : g_entry
      always_ff @(posedge CLK or negedge RST_N)
      begin
        if (!RST_N)
          res_reg[g] <= acd_pkg::RES_RESET;
        else if (port.wr_en && (port.wr_ch == 3'(g)))
          res_reg[g] <= port.wr_data;
      end
    end
  endgenerate

  // registered read; out-of-range channels read zero
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      rd_data_reg <= acd_pkg::RES_RESET;
    else if (port.rd_ch <= acd_pkg::CH_LAST)
      rd_data_reg <= res_reg[port.rd_ch];
    else
      rd_data_reg <= acd_pkg::RES_RESET;
  end

  assign port.rd_data = rd_data_reg;

endmodule

// [testbench/acd_top_sva.sv]
`timescale 1ns/1ps
module acd_top_chk
(
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic       REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic       REG_DEFAULTS,
  input wire logic       CONV_START,
  input wire logic [2:0] CONV_CH,
  input wire logic       CONV_DONE,
  input wire logic       CONV_BUSY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [7:0] dis_reg;
  logic       wr_dis;
  // mask shadow, only valid because masks change while idle
  assign wr_dis = REG_WR && REG_ADDR == 8'h27 && !REG_DEFAULTS;
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      dis_reg <= 8'h00;
    else if (REG_DEFAULTS)
      dis_reg <= 8'h00;
    else if (wr_dis)
      dis_reg <= REG_WDATA & 8'hFC;
  sequence s_turn_on;
    !CONV_BUSY && !REG_WR ##1 !CONV_BUSY && REG_WR && REG_ADDR == 8'h26
      && REG_WDATA[7] && !REG_DEFAULTS && dis_reg == 8'h00;
  endsequence
  wr_readback_a: assert property (
    wr_dis ##1 REG_RD && REG_ADDR == 8'h27
    |=> REG_RDATA == ($past(REG_WDATA, 2) & 8'hFC)) else $error("readback");
  dflt_clear_a: assert property (
    REG_DEFAULTS ##1 REG_RD && REG_ADDR == 8'h27 |=> REG_RDATA == 8'h00)
    else $error("defaults");
  unmapped_rd_a: assert property (
    REG_RD && REG_ADDR != 8'h26 && REG_ADDR != 8'h27 |=> REG_RDATA == 8'h00)
    else $error("unmapped");
  rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("rdata moved");
  skip_off_a: assert property (CONV_START |-> !dis_reg[7 - CONV_CH])
    else $error("disabled channel");
  start_busy_a: assert property (
    CONV_START |-> CONV_BUSY && CONV_CH <= 3'h5) else $error("start idle");
  start_pulse_a: assert property (CONV_START |=> !CONV_START)
    else $error("long start");
  done_gap_a: assert property (
    CONV_DONE |-> !CONV_START ##1 !CONV_START) else $error("start gap");
  turn_on_a: assert property (
    s_turn_on |-> ##3 CONV_START && CONV_CH == 3'h0) else $error("turn on");
endmodule
////////////////////////////////////////
bind acd_top acd_top_chk i_acd_top_chk (.CLK(CLK), .RST_N(RST_N),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_DEFAULTS(REG_DEFAULTS),
  .CONV_START(CONV_START), .CONV_CH(CONV_CH), .CONV_DONE(CONV_DONE),
  .CONV_BUSY(CONV_BUSY));

// [testbench/acd_top_tb.sv]
`timescale 1ns/1ps
module acd_top_tb;
  logic        CLK = '0, RST_N = '0, REG_WR = '0, REG_RD = '0;
  logic        REG_DEFAULTS = '0, CONV_DONE = '0, CONV_START, CONV_BUSY;
  logic [7:0]  REG_ADDR = '0, REG_WDATA = '0, REG_RDATA, mask;
  logic [2:0]  RES_CH = '0, CONV_CH;
  logic [15:0] CONV_DATA = '0, RES_DATA, res_m [8];
  int          n_fail = 0, checks_done = 0, last, n_conv;
  acd_top i_acd_top (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .REG_DEFAULTS(REG_DEFAULTS),
    .CONV_START(CONV_START), .CONV_CH(CONV_CH), .CONV_DONE(CONV_DONE),
    .CONV_DATA(CONV_DATA), .RES_CH(RES_CH), .RES_DATA(RES_DATA),
    .CONV_BUSY(CONV_BUSY));
  always #2.5 CLK = ~CLK;
  task automatic chk(input logic [15:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // strobes stay up between like transfers, so none toggles in one step
  task automatic wr(input logic [7:0] a, d, input logic df);
    REG_RD = 1'h0;
    REG_WR = 1'h1;
    REG_ADDR = a;
    REG_WDATA = d;
    REG_DEFAULTS = df;
    @(posedge CLK);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    REG_WR = 1'h0;
    REG_DEFAULTS = 1'h0;
    REG_RD = 1'h1;
    REG_ADDR = a;
    @(posedge CLK);
    #1;
    chk(16'(REG_RDATA), 16'(exp), "reg_rdata");
  endtask
  task automatic nop;
    REG_WR = 1'h0;
    REG_RD = 1'h0;
    @(posedge CLK);
    #1;
  endtask
  task automatic rres;
    for (int c = 0; c < 8; c++)
    begin
      RES_CH = 3'(c);
      repeat (2) @(posedge CLK);
      #1;
      chk(RES_DATA, res_m[c], "res_data");
    end
  endtask
  // next enabled channel in ascending order, wrapping for continuous
  function automatic int nxt(input int l);
    for (int c = l + 1; c < 12; c++)
      if (!mask[7 - c % 6])
        return c % 6;
    return -1;
  endfunction
  // converter stand-in: random latency and data, model keeps results
  always @(posedge CLK)
    if (CONV_START)
    begin
      chk(16'(CONV_CH), 16'(nxt(last)), "conv_ch");
      last = CONV_CH;
      n_conv++;
      repeat ($urandom_range(3)) @(posedge CLK);
      #1;
      CONV_DONE = 1'h1;
      CONV_DATA = 16'($urandom);
      res_m[CONV_CH] = CONV_DATA;
      @(posedge CLK);
      #1;
      CONV_DONE = 1'h0;
    end
  task automatic pass(input logic [7:0] m, ctl, input int span);
    mask = m & 8'hFC;
    last = -1;
    n_conv = 0;
    wr(8'h27, m, 1'h0);
    rd(8'h27, mask);
    wr(8'h26, ctl, 1'h0);
    repeat (span) nop;
    if (!ctl[6])
      wr(8'h26, 8'h00, 1'h0);
    // busy rises two edges after the on bit is written
    repeat (2) nop;
    for (int i = 0; i < 400 && CONV_BUSY !== 1'b0; i++)
      @(posedge CLK);
    #1;
    chk(16'(CONV_BUSY), 16'h0000, "conv_busy");
    rd(8'h26, ctl & 8'h40);
    if (ctl[6])
      chk(16'(n_conv), 16'(6 - $countones(mask)), "conv_count");
    rres;
    $display("pass done mask %h ctl %h", m, ctl);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog, far beyond the several hundred cycles the tests take
  initial
  begin
    #100000;
    n_fail++;
    complete_run;
  end
  initial
  begin
    void'($urandom(32'h907f_dc03));
    res_m = '{default: 16'h0000};
    repeat (5) @(posedge CLK);
    #1;
    RST_N = 1'h1;
    rd(8'h27, 8'h00);
    rd(8'h28, 8'h00);
    rres;
    // each bit alone, reserved bits read zero
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h27, 8'h01 << i, 1'h0);
      rd(8'h27, (8'h01 << i) & 8'hFC);
    end
    wr(8'h27, 8'hFF, 1'h1);
    rd(8'h27, 8'h00);
    $display("register test done");
    pass(8'h00, 8'hC0, 0);
    for (int k = 0; k < 6; k++)
      pass(8'($urandom), 8'hC0, 0);
    pass(8'hFC, 8'hC0, 0);
    pass(8'($urandom), 8'h80, 80);
    pass(8'h00, 8'h80, 40);
    complete_run;
  end
endmodule
